// File: ssp_ext_master.sv
// External shift-clock master that drives and samples the serial data line
`timescale 1ns/1ps
`default_nettype none
module ssp_ext_master (
	input wire logic clk_i,
	input wire logic dat_i,
	output logic sck_o,
	output logic dat_o
);
	initial begin
		sck_o = 1'b0;
		dat_o = 1'b0;
	end
	// Clock idles low between frames; four clk each half gives an 80 ns period
	task automatic xfer(input int n, input logic [8:0] tv, output logic [8:0] rv);
		rv = 9'h000;
		for (int i = 0; i < n; i++) begin
			// one clock per bit, change on leading edge
			@(posedge clk_i);
			sck_o <= 1'b1;
			dat_o <= tv[i];
			repeat (4) @(posedge clk_i);
			rv[i] = dat_i;
			sck_o <= 1'b0;
			repeat (3) @(posedge clk_i);
		end
		// Released line shows the inverse of its last bit
		@(posedge clk_i);
		dat_o <= ~dat_o;
	endtask
endmodule
`default_nettype wire

// File: ssp_pkg.sv
// Register map, field positions and shared types of the synchronous slave serial port
package ssp_pkg;
	localparam int ADDR_W = 5;
	// Register byte addresses, one aligned word each
	localparam logic [4:0] OFF_BAUD_CTRL = 5'h00;
	localparam logic [4:0] OFF_RX_STAT = 5'h04;
	localparam logic [4:0] OFF_DIV_LO = 5'h08;
	localparam logic [4:0] OFF_DIV_HI = 5'h0c;
	localparam logic [4:0] OFF_TX_HOLD = 5'h10;
	localparam logic [4:0] OFF_TX_STAT = 5'h14;
	localparam logic [4:0] OFF_RX_DATA = 5'h18;
	localparam logic [4:0] OFF_IRQ_CTRL = 5'h1c;
	// serial_baud_control fields
	localparam int BC_CLK_IDLE = 4;
	localparam logic [7:0] BC_WMASK = 8'h1b;
	// receive_status_control fields
	localparam int RS_PORT_EN = 7;
	localparam int RS_RX9 = 6;
	localparam int RS_SINGLE = 5;
	localparam int RS_CONT = 4;
	localparam int RS_OVERRUN = 1;
	localparam int RS_RX_NINTH_BIT = 0;
	localparam logic [7:0] RS_WMASK = 8'hf8;
	// transmit_status_control fields
	localparam int TS_CLK_MASTER = 7;
	localparam int TS_TX9 = 6;
	localparam int TS_TRANSMIT_ENABLE = 5;
	localparam int TS_SYNC = 4;
	localparam int TS_TRMT = 1;
	localparam int TS_TX_NINTH_BIT = 0;
	localparam logic [7:0] TS_WMASK = 8'hfd;
	// Interrupt control fields
	localparam int IC_GLOBAL = 7;
	localparam int IC_PERIPH = 6;
	localparam int IC_RXIE = 5;
	localparam int IC_TX_IRQ_ENABLE = 4;
	localparam int IC_RXF = 1;
	localparam int IC_TXF = 0;
	localparam logic [7:0] IC_WMASK = 8'hf0;
	// Reset values
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] TS_RESET = 8'h00;
	// Character lengths and receive buffer depth
	localparam logic [3:0] BITS_SHORT = 4'h8;
	localparam logic [3:0] BITS_LONG = 4'h9;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;

	typedef struct packed {
		logic ninth;
		logic [7:0] data;
	} ssp_char_t;
endpackage

// File: ssp_slave_port.sv
// Synchronous slave serial port with Wishbone registers, two-character receive buffer and Sleep wake
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_port
	import ssp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic sleep_i,
	input wire logic sck_i,
	input wire logic data_in_i,
	output logic data_out_o,
	output logic data_oe_o,
	output logic wake_o,
	output logic irq_o,
	output logic tx_flag_o,
	output logic rx_flag_o
);
	function automatic logic [3:0] char_bits(input logic ninth_en);
		char_bits = ninth_en ? BITS_LONG : BITS_SHORT;
	endfunction

	logic ack_reg;
	logic [31:0] dat_reg;
	logic [7:0] baud_ctrl_reg;
	logic [7:0] rx_ctrl_reg;
	logic [7:0] div_lo_reg;
	logic [7:0] div_hi_reg;
	logic [7:0] tx_ctrl_reg;
	logic [7:0] irq_ctrl_reg;
	logic sck_meta_reg, sck_sync_reg, sck_prev_reg;
	logic din_meta_reg, din_sync_reg;
	ssp_char_t hold_reg;
	logic hold_full_reg;
	logic [8:0] tx_sh_reg;
	logic tx_busy_reg, tx_first_reg;
	logic [3:0] tx_cnt_reg;
	logic [3:0] tx_nbits_reg;
	logic [7:0] rx_sh_reg;
	logic [3:0] rx_cnt_reg;
	ssp_char_t fifo_reg [2];
	logic wr_ptr_reg, rd_ptr_reg;
	logic [1:0] fifo_cnt_reg;
	logic overrun_reg;
	logic tx_flag_prev_reg;
	logic wake_reg;
	logic [31:0] rd_next;

	logic acc, bus_wr, bus_rd;
	logic unit_rst, slave_mode, tx_dir, rx_en, clk_idle;
	logic sck_change, lead_edge, trail_edge;
	logic wr_hold, tx_load, tx_last;
	logic rx_last, rx_done, pop, push;
	logic tx_flag, rx_flag;
	ssp_char_t rx_char;
	ssp_char_t fifo_top;

	assign acc = cyc_i && stb_i && !ack_reg;
	assign bus_wr = acc && we_i && sel_i[0];
	assign bus_rd = acc && !we_i;
	assign unit_rst = rst_i || !rx_ctrl_reg[RS_PORT_EN];
	assign slave_mode = tx_ctrl_reg[TS_SYNC] && rx_ctrl_reg[RS_PORT_EN] && !tx_ctrl_reg[TS_CLK_MASTER];
	assign tx_dir = slave_mode && !rx_ctrl_reg[RS_CONT] && !rx_ctrl_reg[RS_SINGLE];
	assign rx_en = slave_mode && rx_ctrl_reg[RS_CONT];
	assign clk_idle = baud_ctrl_reg[BC_CLK_IDLE];
	// leading edge leaves idle, trailing edge returns
	assign sck_change = sck_sync_reg != sck_prev_reg;
	assign lead_edge = sck_change && (sck_sync_reg != clk_idle);
	assign trail_edge = sck_change && (sck_sync_reg == clk_idle);

	// Wishbone slave: one wait state, ack for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
		end else begin
			ack_reg <= acc;
			if (bus_rd) begin
				dat_reg <= rd_next;
			end
		end
	end
	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			baud_ctrl_reg <= REG_RESET;
			rx_ctrl_reg <= REG_RESET;
			div_lo_reg <= REG_RESET;
			div_hi_reg <= REG_RESET;
			tx_ctrl_reg <= TS_RESET;
			irq_ctrl_reg <= REG_RESET;
		end else if (bus_wr) begin
			case (adr_i)
				OFF_BAUD_CTRL: baud_ctrl_reg <= dat_i[7:0] & BC_WMASK;
				OFF_RX_STAT: rx_ctrl_reg <= dat_i[7:0] & RS_WMASK;
				OFF_DIV_LO: div_lo_reg <= dat_i[7:0];
				OFF_DIV_HI: div_hi_reg <= dat_i[7:0];
				OFF_TX_STAT: tx_ctrl_reg <= dat_i[7:0] & TS_WMASK;
				OFF_IRQ_CTRL: irq_ctrl_reg <= dat_i[7:0] & IC_WMASK;
				default: ;
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_next = 32'h0;
		case (adr_i)
			OFF_BAUD_CTRL: rd_next[7:0] = baud_ctrl_reg;
			OFF_RX_STAT: begin
				rd_next[7:0] = rx_ctrl_reg;
				rd_next[RS_OVERRUN] = overrun_reg;
				rd_next[RS_RX_NINTH_BIT] = fifo_top.ninth;
			end
			OFF_DIV_LO: rd_next[7:0] = div_lo_reg;
			OFF_DIV_HI: rd_next[7:0] = div_hi_reg;
			OFF_TX_STAT: begin
				rd_next[7:0] = tx_ctrl_reg;
				rd_next[TS_TRMT] = !tx_busy_reg;
			end
			OFF_RX_DATA: rd_next[7:0] = fifo_top.data;
			OFF_IRQ_CTRL: begin
				rd_next[7:0] = irq_ctrl_reg;
				rd_next[IC_RXF] = rx_flag;
				rd_next[IC_TXF] = tx_flag;
			end
			default: rd_next = 32'h0;
		endcase
	end

	// Pin synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sck_meta_reg <= 1'b0;
			sck_sync_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
			din_meta_reg <= 1'b0;
			din_sync_reg <= 1'b0;
		end else begin
			sck_meta_reg <= sck_i;
			sck_sync_reg <= sck_meta_reg;
			sck_prev_reg <= sck_sync_reg;
			din_meta_reg <= data_in_i;
			din_sync_reg <= din_meta_reg;
		end
	end

	// Transmit holding register and shifter
	// write accepted only with transmit enable
	assign wr_hold = bus_wr && (adr_i == OFF_TX_HOLD) && tx_ctrl_reg[TS_TRANSMIT_ENABLE];
	// shifter loads as soon as it is free, Sleep or not
	assign tx_load = tx_dir && tx_ctrl_reg[TS_TRANSMIT_ENABLE] && hold_full_reg && !tx_busy_reg;
	assign tx_last = tx_busy_reg && trail_edge && (tx_cnt_reg + 4'h1 == tx_nbits_reg);

	always_ff @(posedge clk_i) begin
		if (unit_rst) begin
			hold_reg <= '0;
			hold_full_reg <= 1'b0;
			tx_sh_reg <= 9'h0;
			tx_busy_reg <= 1'b0;
			tx_first_reg <= 1'b0;
			tx_cnt_reg <= 4'h0;
			tx_nbits_reg <= BITS_SHORT;
		end else begin
			// second character stays held while first shifts
			if (tx_load) begin
				hold_full_reg <= 1'b0;
				// ninth bit above the low eight
				tx_sh_reg <= {hold_reg.ninth, hold_reg.data};
				tx_nbits_reg <= char_bits(tx_ctrl_reg[TS_TX9]);
				tx_busy_reg <= 1'b1;
				tx_first_reg <= 1'b1;
				tx_cnt_reg <= 4'h0;
			end else if (!tx_dir) begin
				tx_busy_reg <= 1'b0;
			end else if (tx_busy_reg) begin
				// bit changes on leading edge, counted on trailing
				if (lead_edge) begin
					tx_first_reg <= 1'b0;
					if (!tx_first_reg) begin
						tx_sh_reg <= {1'b0, tx_sh_reg[8:1]};
					end
				end
				if (trail_edge) begin
					tx_cnt_reg <= tx_cnt_reg + 4'h1;
				end
				// shifter frees; held character follows next cycle
				if (tx_last) begin
					tx_busy_reg <= 1'b0;
				end
			end
			if (wr_hold) begin
				hold_reg <= '{ninth: tx_ctrl_reg[TS_TX_NINTH_BIT], data: dat_i[7:0]};
				hold_full_reg <= 1'b1;
			end
		end
	end
	// flag held low while holding register occupied
	// flag high whenever holding register empty
	assign tx_flag = !hold_full_reg;
	assign data_out_o = tx_sh_reg[0];
	assign data_oe_o = tx_dir && tx_busy_reg;

	// Receive shifter, two-character buffer and overrun
	assign rx_last = rx_cnt_reg + 4'h1 == char_bits(rx_ctrl_reg[RS_RX9]);
	// trailing edges are taken while enabled and no overrun stands
	assign rx_done = rx_en && !overrun_reg && trail_edge && rx_last;
	assign pop = bus_rd && (adr_i == OFF_RX_DATA) && (fifo_cnt_reg != 2'h0);
	assign push = rx_done && ((fifo_cnt_reg != FIFO_DEPTH) || pop);
	assign fifo_top = fifo_reg[rd_ptr_reg];
	always_comb begin
		rx_char = '0;
		if (rx_ctrl_reg[RS_RX9]) begin
			rx_char.ninth = din_sync_reg;
			rx_char.data = rx_sh_reg;
		end else begin
			rx_char.data = {din_sync_reg, rx_sh_reg[6:0]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (unit_rst || !rx_en) begin
			rx_sh_reg <= 8'h0;
			rx_cnt_reg <= 4'h0;
		end else if (trail_edge && !overrun_reg) begin
			// sample on trailing edge, low bit first
			if (rx_last) begin
				rx_cnt_reg <= 4'h0;
			end else begin
				rx_sh_reg[rx_cnt_reg[2:0]] <= din_sync_reg;
				rx_cnt_reg <= rx_cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (unit_rst) begin
			fifo_reg[0] <= '0;
			fifo_reg[1] <= '0;
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			fifo_cnt_reg <= 2'h0;
		end else begin
			// completed character moves into receive data
			if (push) begin
				fifo_reg[wr_ptr_reg] <= rx_char;
				wr_ptr_reg <= !wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= !rd_ptr_reg;
			end
			fifo_cnt_reg <= fifo_cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// overrun clears with continuous receive or port enable
	always_ff @(posedge clk_i) begin
		if (unit_rst || !rx_ctrl_reg[RS_CONT]) begin
			overrun_reg <= 1'b0;
		end else if (rx_done && !push) begin
			overrun_reg <= 1'b1;
		end
	end
	// flag stands while unread characters remain
	assign rx_flag = fifo_cnt_reg != 2'h0;

	// Wake from Sleep and interrupt request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_flag_prev_reg <= 1'b1;
			wake_reg <= 1'b0;
		end else begin
			tx_flag_prev_reg <= tx_flag;
			// tx flag rise wakes with both enables
			// received character wakes with its enable
			wake_reg <= sleep_i && ((tx_flag && !tx_flag_prev_reg && irq_ctrl_reg[IC_PERIPH]
				&& irq_ctrl_reg[IC_TX_IRQ_ENABLE]) || (push && irq_ctrl_reg[IC_RXIE]));
		end
	end
	assign wake_o = wake_reg;
	// transmit or receive interrupt when enabled; global and peripheral enables gate the request
	assign irq_o = irq_ctrl_reg[IC_GLOBAL] && irq_ctrl_reg[IC_PERIPH]
		&& ((tx_flag && irq_ctrl_reg[IC_TX_IRQ_ENABLE]) || (rx_flag && irq_ctrl_reg[IC_RXIE]));
	assign tx_flag_o = tx_flag;
	assign rx_flag_o = rx_flag;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	bus_ack_a: assert property (ack_o |=> !ack_o) else $error("ack held two cycles");
	hold_flag_a: assert property (hold_full_reg |-> !tx_flag_o) else $error("tx flag with holding full");
	empty_flag_a: assert property (!unit_rst && !hold_full_reg && !$past(wr_hold) |-> tx_flag_o)
		else $error("tx flag low with holding empty");
	tx_dir_a: assert property (data_oe_o |-> !rx_ctrl_reg[RS_CONT] && !rx_ctrl_reg[RS_SINGLE]
		&& slave_mode) else $error("data driven outside transmit direction");
	ninth_load_a: assert property (tx_load && tx_ctrl_reg[TS_TX9] |=> tx_sh_reg[8] == $past(hold_reg.ninth)
		&& tx_nbits_reg == BITS_LONG) else $error("ninth bit not loaded");
	no_transmit_enable_a: assert property (bus_wr && adr_i == OFF_TX_HOLD && !tx_ctrl_reg[TS_TRANSMIT_ENABLE] && !hold_full_reg
		&& !unit_rst |=> !hold_full_reg) else $error("write accepted without enable");
	reload_a: assert property (tx_last && hold_full_reg && tx_dir && tx_ctrl_reg[TS_TRANSMIT_ENABLE] && !unit_rst
		|=> !tx_busy_reg ##1 tx_busy_reg && tx_flag_o) else $error("held character not reloaded");
	rx_flag_a: assert property (push && !pop |=> rx_flag_o) else $error("rx flag missing");
	overrun_set_a: assert property (rx_done && fifo_cnt_reg == FIFO_DEPTH && !pop |=> overrun_reg
		&& $stable(fifo_cnt_reg)) else $error("overrun not flagged");
	overrun_clr_a: assert property (!rx_ctrl_reg[RS_CONT] |=> !overrun_reg) else $error("overrun kept");
	tx_wake_a: assert property (sleep_i && tx_flag && !tx_flag_prev_reg && irq_ctrl_reg[IC_PERIPH]
		&& irq_ctrl_reg[IC_TX_IRQ_ENABLE] |=> wake_o) else $error("no wake on tx flag");
	rx_wake_a: assert property (sleep_i && push && irq_ctrl_reg[IC_RXIE] |=> wake_o)
		else $error("no wake on receive");
	port_off_a: assert property (!rx_ctrl_reg[RS_PORT_EN] |=> !overrun_reg && fifo_cnt_reg == 2'h0
		&& !hold_full_reg && !tx_busy_reg) else $error("serial state kept with port off");
	slave_sel_a: assert property (data_oe_o |-> tx_ctrl_reg[TS_SYNC] && !tx_ctrl_reg[TS_CLK_MASTER]
		&& rx_ctrl_reg[RS_PORT_EN]) else $error("data driven outside slave mode");
	tx_first_a: assert property (tx_load && !bus_wr |=> data_oe_o
		&& data_out_o == $past(hold_reg.data[0])) else $error("first bit not presented at load");
	shift_hold_a: assert property (tx_busy_reg && !lead_edge && !unit_rst |=> $stable(tx_sh_reg))
		else $error("transmit bit changed off a leading edge");
	tx_count_a: assert property (tx_busy_reg |-> tx_cnt_reg < tx_nbits_reg)
		else $error("transmit bit count overran");
	oe_idle_a: assert property (!tx_busy_reg |-> !data_oe_o)
		else $error("data driven with shifter idle");
	rx_ninth_a: assert property (push && fifo_cnt_reg == 2'h0 && rx_ctrl_reg[RS_RX9]
		|=> fifo_top.ninth == $past(din_sync_reg)) else $error("ninth received bit lost");
	rx_block_a: assert property (overrun_reg |-> !push)
		else $error("character taken during overrun");
	irq_rx_a: assert property (rx_flag_o && irq_ctrl_reg[IC_RXIE] && irq_ctrl_reg[IC_PERIPH]
		&& irq_ctrl_reg[IC_GLOBAL] |-> irq_o) else $error("receive interrupt missing");
	rx_clear_a: assert property (fifo_cnt_reg == 2'h1 && pop && !push |=> !rx_flag_o)
		else $error("rx flag kept after last read");
	wake_sleep_a: assert property (wake_o |-> $past(sleep_i))
		else $error("wake outside Sleep");

	// Main transfers, buffer fill, overrun and wake
	tx_done_c: cover property (tx_last ##[1:3] tx_load);
	rx_two_c: cover property (push && fifo_cnt_reg == 2'h1);
	overrun_c: cover property ($rose(overrun_reg));
	wake_c: cover property (wake_o);
	tx_sleep_c: cover property (sleep_i && tx_last && hold_full_reg);
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the synchronous slave serial port
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ssp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [4:0] adr_i = 5'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic sleep_i = 1'b0;
	logic sck, m_dat, data_in_i, data_out_o, data_oe_o, wake_o, irq_o, tx_flag_o, rx_flag_o, ack_o;
	logic [31:0] dat_o;
	int errors = 0;
	int n_tests = 0;
	int wake_cnt = 0;
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		if (wake_o === 1'b1) begin
			wake_cnt <= wake_cnt + 1;
		end
	end
	assign data_in_i = (data_oe_o === 1'b1) ? data_out_o : m_dat;
	ssp_slave_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i),
		.sck_i(sck), .data_in_i(data_in_i), .data_out_o(data_out_o), .data_oe_o(data_oe_o),
		.wake_o(wake_o), .irq_o(irq_o), .tx_flag_o(tx_flag_o), .rx_flag_o(rx_flag_o));
	ssp_ext_master u_mst (.clk_i(clk_i), .dat_i(data_in_i), .sck_o(sck), .dat_o(m_dat));
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
		int k;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'hf;
		dat_i <= {24'h0, d};
		for (k = 0; k < 20; k++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1) break;
		end
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		if (k == 20) begin
			errors++;
			conclude();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] e);
		logic [31:0] q;
		wb(1'b0, a, 8'h00, q);
		chk(nm, {24'h0, e}, q);
	endtask
	task automatic wait_flag(input bit rx);
		int k;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_i);
			if ((rx ? rx_flag_o : tx_flag_o) === 1'b1) break;
		end
		if (k == 50) begin
			errors++;
			conclude();
		end
	endtask
	task automatic t_reset();
		chk("tx_flag", 1, tx_flag_o);
		chk("rx_flag", 0, rx_flag_o);
		chk("oe", 0, data_oe_o);
		rdc("rx_stat", OFF_RX_STAT, 8'h00);
		rdc("irq_ctrl", OFF_IRQ_CTRL, 8'h01);
		wr(OFF_RX_DATA, 8'h5a);
		rdc("rx_data ro", OFF_RX_DATA, 8'h00);
		rdc("tx_hold wo", OFF_TX_HOLD, 8'h00);
	endtask
	task automatic t_tx_sleep();
		logic [8:0] r;
		int w0;
		wr(OFF_RX_STAT, 8'h80);
		wr(OFF_TX_STAT, 8'h30);
		wr(OFF_IRQ_CTRL, 8'hd0);
		wr(OFF_TX_HOLD, 8'hc3);
		wr(OFF_TX_HOLD, 8'h96);
		sleep_i <= 1'b1;
		w0 = wake_cnt;
		chk("tx_flag held", 0, tx_flag_o);
		chk("oe", 1, data_oe_o);
		u_mst.xfer(8, 9'h000, r);
		chk("first char", 9'h0c3, r);
		wait_flag(0);
		// Wake pulse trails the flag by a cycle and is counted one cycle later
		repeat (3) @(posedge clk_i);
		chk("wake tx", 1, wake_cnt - w0);
		chk("irq tx", 1, irq_o);
		sleep_i <= 1'b0;
		u_mst.xfer(8, 9'h000, r);
		chk("second char", 9'h096, r);
		wr(OFF_TX_STAT, 8'h71);
		wr(OFF_TX_HOLD, 8'h3c);
		u_mst.xfer(9, 9'h000, r);
		chk("ninth tx", 9'h13c, r);
		wr(OFF_TX_STAT, 8'h10);
		wr(OFF_TX_HOLD, 8'h11);
		chk("tx off", 1, tx_flag_o);
	endtask
	task automatic t_rx_sleep();
		logic [8:0] r;
		int w0;
		wr(OFF_IRQ_CTRL, 8'h20);
		wr(OFF_RX_STAT, 8'hf0);
		sleep_i <= 1'b1;
		w0 = wake_cnt;
		u_mst.xfer(9, 9'h1a5, r);
		wait_flag(1);
		chk("wake rx", 1, wake_cnt - w0);
		chk("irq gated", 0, irq_o);
		sleep_i <= 1'b0;
		rdc("rx ninth", OFF_RX_STAT, 8'hf1);
		rdc("rx data", OFF_RX_DATA, 8'ha5);
		chk("rx empty", 0, rx_flag_o);
	endtask
	task automatic t_overrun();
		logic [8:0] r;
		wr(OFF_RX_STAT, 8'h90);
		u_mst.xfer(8, 9'h011, r);
		u_mst.xfer(8, 9'h022, r);
		u_mst.xfer(8, 9'h033, r);
		repeat (8) @(posedge clk_i);
		rdc("overrun", OFF_RX_STAT, 8'h92);
		u_mst.xfer(8, 9'h044, r);
		rdc("keep 1", OFF_RX_DATA, 8'h11);
		rdc("keep 2", OFF_RX_DATA, 8'h22);
		chk("blocked", 0, rx_flag_o);
		wr(OFF_RX_STAT, 8'h80);
		rdc("ovr clr", OFF_RX_STAT, 8'h80);
		wr(OFF_RX_STAT, 8'h90);
		u_mst.xfer(8, 9'h055, r);
		wait_flag(1);
		wr(OFF_RX_STAT, 8'h10);
		// Unit reset acts on the edge after the port enable falls
		@(posedge clk_i);
		chk("port off", 0, rx_flag_o);
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_tx_sleep();
		t_rx_sleep();
		t_overrun();
		conclude();
	end
endmodule
`default_nettype wire
